// ### design/pmt8_pkg.sv
// Package of constants for the period match timer
package pmt8_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] PMT8_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] PMT8_COUNT_ADDR = 8'h04;
  localparam logic [7:0] PMT8_PERIOD_ADDR = 8'h08;
  localparam logic [7:0] PMT8_STATUS_ADDR = 8'h0C;
  localparam logic [7:0] PMT8_ENABLE_ADDR = 8'h10;
  localparam logic [7:0] PMT8_CLEAR_ADDR = 8'h14;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int PMT8_PRE_LSB = 0;
  localparam int PMT8_ON_BIT = 2;
  localparam int PMT8_POST_LSB = 3;
  localparam logic [6:0] PMT8_CONTROL_RESET = 7'h00;
  localparam logic [7:0] PMT8_COUNT_RESET = 8'h00;
  localparam logic [7:0] PMT8_PERIOD_RESET = 8'hFF;
  // ----------------------------------------
  // Cycle counts
  // ----------------------------------------
  localparam int PMT8_INSTR_DIV = 4;
  localparam logic [3:0] PMT8_PRE_MAX_4 = 4'h3;
  localparam logic [3:0] PMT8_PRE_MAX_16 = 4'hF;
endpackage

// ### design/pmt8_prescaler.sv
// Instruction clock divider and timer prescaler
module pmt8_prescaler
  import pmt8_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic clear,
  input wire logic [1:0] prescale_select,
  output logic tick
);
  logic [1:0] phase_reg, phase_next;
  logic [3:0] pre_reg, pre_next;
  logic [3:0] pre_max;
  logic instr;

  // ----------------------------------------
  // Divide by four then by 1, 4 or 16
  // ----------------------------------------
  always_comb begin
    phase_next = phase_reg + 2'h1;
    instr = (phase_reg == 2'(PMT8_INSTR_DIV - 1));
    case (prescale_select)
      2'h0: pre_max = 4'h0;
      2'h1: pre_max = PMT8_PRE_MAX_4;
      default: pre_max = PMT8_PRE_MAX_16;
    endcase
    pre_next = pre_reg;
    tick = 1'b0;
    if (run && instr) begin
      if (pre_reg >= pre_max) begin
        pre_next = 4'h0;
        tick = 1'b1;
      end else begin
        pre_next = pre_reg + 4'h1;
      end
    end
    if (clear) begin
      pre_next = 4'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= 2'h0;
      pre_reg <= 4'h0;
    end else begin
      phase_reg <= phase_next;
      pre_reg <= pre_next;
    end
  end
endmodule

// ### design/pmt8_top.sv
// Period match timer with AHB-Lite register slave
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
module pmt8_top
  import pmt8_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic pwm_time_base,
  output logic irq
);
  logic [6:0] control_reg, control_next;
  logic [7:0] count_reg, count_next;
  logic [7:0] period_reg, period_next;
  logic [3:0] post_reg, post_next;
  logic flag_reg, flag_next;
  logic enable_reg, enable_next;
  logic match_reg, match_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  logic tick, match, set_flag;
  logic wr_count, wr_control, wr_period, wr_enable, wr_clear;
  logic presc_clear;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  // Zero wait states, so reads are answered from the address phase
  // Next values are read so a write just before a read is seen
  logic take;
  assign take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;

  always_comb begin
    wr_pend_next = take && hwrite;
    wr_addr_next = take ? haddr : wr_addr_reg;
    rdata_next = rdata_reg;
    if (take && !hwrite) begin
      case (haddr)
        PMT8_CONTROL_ADDR: rdata_next = 32'(control_next);
        PMT8_COUNT_ADDR: rdata_next = 32'(count_next);
        PMT8_PERIOD_ADDR: rdata_next = 32'(period_next);
        PMT8_STATUS_ADDR: rdata_next = 32'(flag_next);
        PMT8_ENABLE_ADDR: rdata_next = 32'(enable_next);
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      rdata_reg <= rdata_next;
    end
  end

  assign wr_control = wr_pend_reg && hit(wr_addr_reg, PMT8_CONTROL_ADDR);
  assign wr_count = wr_pend_reg && hit(wr_addr_reg, PMT8_COUNT_ADDR);
  assign wr_period = wr_pend_reg && hit(wr_addr_reg, PMT8_PERIOD_ADDR);
  assign wr_enable = wr_pend_reg && hit(wr_addr_reg, PMT8_ENABLE_ADDR);
  assign wr_clear = wr_pend_reg && hit(wr_addr_reg, PMT8_CLEAR_ADDR);
  assign presc_clear = wr_control || wr_count;

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  pmt8_prescaler i_pmt8_prescaler (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(control_reg[PMT8_ON_BIT]),
    .clear(presc_clear),
    .prescale_select(control_reg[PMT8_PRE_LSB +: 2]),
    .tick(tick)
  );

  // ----------------------------------------
  // Counter, postscaler and flag
  // ----------------------------------------
  always_comb begin
    control_next = control_reg;
    period_next = period_reg;
    count_next = count_reg;
    post_next = post_reg;
    enable_next = enable_reg;
    match = 1'b0;
    set_flag = 1'b0;
    if (wr_control) begin
      control_next = hwdata[6:0];
    end
    if (wr_period) begin
      period_next = hwdata[7:0];
    end
    if (wr_enable) begin
      enable_next = hwdata[0];
    end
    // Stopped timer holds count; prescaler gates ticks
    if (tick) begin
      if (count_reg == period_reg) begin
        count_next = 8'h00;
        match = 1'b1;
      end else begin
        count_next = count_reg + 8'h01;
      end
    end
    if (match) begin
      if (post_reg == control_reg[PMT8_POST_LSB +: 4]) begin
        post_next = 4'h0;
        set_flag = 1'b1;
      end else begin
        post_next = post_reg + 4'h1;
      end
    end
    if (wr_count) begin
      count_next = hwdata[7:0];
    end
    if (presc_clear) begin
      post_next = 4'h0;
    end
    // Set wins over a clear in the same cycle
    flag_next = set_flag || (flag_reg && !(wr_clear && hwdata[0]));
    match_next = match;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control_reg <= PMT8_CONTROL_RESET;
      count_reg <= PMT8_COUNT_RESET;
      period_reg <= PMT8_PERIOD_RESET;
      post_reg <= 4'h0;
      flag_reg <= 1'b0;
      enable_reg <= 1'b0;
      match_reg <= 1'b0;
    end else begin
      control_reg <= control_next;
      count_reg <= count_next;
      period_reg <= period_next;
      post_reg <= post_next;
      flag_reg <= flag_next;
      enable_reg <= enable_next;
      match_reg <= match_next;
    end
  end

  assign pwm_time_base = match_reg;
  assign irq = flag_reg && enable_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  count_wrap_a: assert property (
    (tick && count_reg == period_reg && !wr_count) |=> count_reg == 8'h00
  ) else $error("count did not wrap at period");

  count_step_a: assert property (
    (tick && count_reg != period_reg && !wr_count)
      |=> count_reg == $past(count_reg) + 8'h01
  ) else $error("count did not step");

  ctrl_keeps_count_a: assert property (
    (wr_control && !tick && !wr_count) |=> $stable(count_reg)
  ) else $error("control write changed count");

  stopped_hold_a: assert property (
    (!control_reg[PMT8_ON_BIT] && !wr_count && !wr_control)
      |=> $stable(count_reg)
  ) else $error("stopped timer moved");

  tick_spacing_a: assert property (
    tick |=> !tick [*3]
  ) else $error("tick faster than instruction clock");

  post_clear_a: assert property (
    presc_clear |=> post_reg == 4'h0
  ) else $error("postscaler not cleared");

  flag_sticky_a: assert property (
    (flag_reg && !wr_clear) |=> flag_reg
  ) else $error("flag dropped without clear");

  flag_cause_a: assert property (
    $rose(flag_reg) |-> $past(match && post_reg ==
      control_reg[PMT8_POST_LSB +: 4])
  ) else $error("flag set without postscale match");

  pwm_pulse_a: assert property (
    pwm_time_base |-> $past(match)
  ) else $error("time base pulse without match");

  irq_gate_a: assert property (
    (wr_enable && !hwdata[0]) |=> !irq
  ) else $error("irq stayed up after enable cleared");

  bit7_zero_a: assert property (
    (take && !hwrite && haddr == PMT8_CONTROL_ADDR)
      |=> rdata_reg[31:7] == 25'h000_0000
  ) else $error("control bit 7 not read as zero");

  // ----------------------------------------
  // Register load and hold, tick gate, time base pulse, postscaler and flag checks
  // ----------------------------------------
  count_load_a: assert property (
    wr_count |=> count_reg == $past(hwdata[7:0])
  ) else $error("count write lost");

  period_load_a: assert property (
    wr_period |=> period_reg == $past(hwdata[7:0])
  ) else $error("period write lost");

  period_hold_a: assert property (
    !wr_period |=> $stable(period_reg)
  ) else $error("period changed without write");

  ctrl_load_a: assert property (
    wr_control |=> control_reg == $past(hwdata[6:0])
  ) else $error("control write lost");

  ctrl_hold_a: assert property (
    !wr_control |=> $stable(control_reg)
  ) else $error("control changed without write");

  enable_load_a: assert property (
    wr_enable |=> enable_reg == $past(hwdata[0])
  ) else $error("enable write lost");

  tick_gate_a: assert property (
    !control_reg[PMT8_ON_BIT] |-> !tick
  ) else $error("tick while timer off");

  pulse_zero_a: assert property (
    (pwm_time_base && !$past(wr_count)) |-> count_reg == 8'h00
  ) else $error("time base pulse without count at zero");

  pulse_single_a: assert property (
    pwm_time_base |=> !pwm_time_base
  ) else $error("time base pulse longer than a cycle");

  post_step_a: assert property (
    (match && post_reg != control_reg[PMT8_POST_LSB +: 4] && !presc_clear)
      |=> post_reg == $past(post_reg) + 4'h1
  ) else $error("postscaler did not step on match");

  post_idle_a: assert property (
    (!match && !presc_clear) |=> $stable(post_reg)
  ) else $error("postscaler moved without match");

  flag_clear_a: assert property (
    (wr_clear && hwdata[0] && !set_flag) |=> !flag_reg
  ) else $error("flag not cleared by write");

  set_wins_a: assert property (
    set_flag |=> flag_reg
  ) else $error("flag not set by postscaler");

  flag_idle_a: assert property (
    (!flag_reg && !set_flag) |=> !flag_reg
  ) else $error("flag set without postscaler");

  // ----------------------------------------
  // Cover points
  // ----------------------------------------
  cover_match_c: cover property (pwm_time_base);
  cover_flag_c: cover property ($rose(flag_reg));
  cover_irq_c: cover property ($rose(irq));
  cover_setclr_c: cover property (set_flag && wr_clear);
  cover_stop_c: cover property ($fell(control_reg[PMT8_ON_BIT]));
endmodule

// ### tb/tb_period_match_timer8.sv
// Self-checking testbench for the period match timer
module tb_period_match_timer8 import pmt8_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic pwm_time_base;
  logic irq;
  wire hready = hreadyout;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  always #50 hclk = ~hclk;
  pmt8_top i_pmt8_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .pwm_time_base(pwm_time_base), .irq(irq));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic conclude();
    $display("compares=%0d errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Entered just after an edge; never assumes a wait-state count
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 99);
    r = hrdata;
    chk(32'(hready), 32'h0000_0001);
    chk(32'(hresp), 32'h0000_0000);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0000_0000, r);
    chk(r, e);
  endtask
  task automatic wait_pulse(output int n);
    n = 0;
    do begin @(posedge hclk); n++; end
    while (pwm_time_base !== 1'b1 && n < 2000);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdc(PMT8_CONTROL_ADDR, 32'h0000_0000);
    rdc(PMT8_COUNT_ADDR, 32'h0000_0000);
    rdc(PMT8_PERIOD_ADDR, 32'h0000_00FF);
    rdc(PMT8_STATUS_ADDR, 32'h0000_0000);
    rdc(8'h18, 32'h0000_0000);
  endtask
  task automatic t_regs();
    wr(PMT8_COUNT_ADDR, 32'h0000_005A);
    rdc(PMT8_COUNT_ADDR, 32'h0000_005A);
    wr(PMT8_PERIOD_ADDR, 32'h0000_0033);
    rdc(PMT8_PERIOD_ADDR, 32'h0000_0033);
    wr(PMT8_CONTROL_ADDR, 32'h0000_0080);
    rdc(PMT8_CONTROL_ADDR, 32'h0000_0000);
    wr(PMT8_CONTROL_ADDR, 32'h0000_007B);
    rdc(PMT8_CONTROL_ADDR, 32'h0000_007B);
    rdc(PMT8_COUNT_ADDR, 32'h0000_005A);
    repeat (100) @(posedge hclk);
    rdc(PMT8_COUNT_ADDR, 32'h0000_005A);
  endtask
  // Pulse spacing is period+1 prescaled ticks of 4, 16 or 64 clocks each
  task automatic t_rate();
    int n;
    wr(PMT8_PERIOD_ADDR, 32'h0000_0003);
    for (int p = 0; p < 4; p++) begin
      wr(PMT8_CONTROL_ADDR, 32'h0000_0000);
      wr(PMT8_COUNT_ADDR, 32'h0000_0000);
      wr(PMT8_CONTROL_ADDR, 32'h0000_0004 | p);
      wait_pulse(n);
      wait_pulse(n);
      chk(n, (p == 0) ? 16 : (p == 1) ? 64 : 256);
    end
    // Count writes every 44 clocks beat the 64-clock prescaled tick
    wr(PMT8_CONTROL_ADDR, 32'h0000_0006);
    for (int k = 0; k < 8; k++) begin
      wr(PMT8_COUNT_ADDR, 32'h0000_0000);
      repeat (40) @(posedge hclk);
      rdc(PMT8_COUNT_ADDR, 32'h0000_0000);
    end
  endtask
  task automatic t_post();
    int m;
    int c;
    int post[3] = '{0, 2, 15};
    wr(PMT8_ENABLE_ADDR, 32'h0000_0001);
    foreach (post[i]) begin
      wr(PMT8_CONTROL_ADDR, 32'h0000_0000);
      wr(PMT8_CLEAR_ADDR, 32'h0000_0001);
      wr(PMT8_COUNT_ADDR, 32'h0000_0000);
      chk(irq, 1'b0);
      wr(PMT8_CONTROL_ADDR, (post[i] << 3) | 4);
      m = 0;
      c = 0;
      while (irq !== 1'b1 && c < 3000) begin
        @(posedge hclk);
        c++;
        if (pwm_time_base === 1'b1) m++;
      end
      chk(m, post[i] + 1);
    end
  endtask
  // Timer stopped first so no new match can set the flag again
  task automatic t_irq();
    wr(PMT8_CONTROL_ADDR, 32'h0000_0000);
    wr(PMT8_ENABLE_ADDR, 32'h0000_0000);
    repeat (50) @(posedge hclk);
    chk(irq, 1'b0);
    rdc(PMT8_STATUS_ADDR, 32'h0000_0001);
    wr(PMT8_ENABLE_ADDR, 32'h0000_0001);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b1);
    wr(PMT8_CLEAR_ADDR, 32'h0000_0001);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b0);
    rdc(PMT8_STATUS_ADDR, 32'h0000_0000);
    rdc(PMT8_CLEAR_ADDR, 32'h0000_0000);
  endtask
  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_regs();
    t_rate();
    t_post();
    t_irq();
    conclude();
  end
endmodule
